// ---- core/sebs_consts.vh ----
// Constants for the two-wire serial EEPROM bus slave.
// Assumes a 200 MHz system clock sampling the bus pins.
`ifndef SEBS_CONSTS_VH
`define SEBS_CONSTS_VH

// Memory shape
`define SEBS_ADDR_W        11
`define SEBS_MEM_WORDS     2048
`define SEBS_PAGE_BYTES    16
`define SEBS_ERASED_BYTE   8'hFF

// Command byte fields
`define SEBS_CMD_FIXED_BIT 7
`define SEBS_CMD_SEL2_BIT  6
`define SEBS_CMD_SEL1_BIT  5
`define SEBS_CMD_SEL0_BIT  4
`define SEBS_CMD_UPPER_HI  3
`define SEBS_CMD_UPPER_LO  1
`define SEBS_CMD_RW_BIT    0

// Bit counter positions within a nine-clock byte
`define SEBS_LAST_DATA_BIT 4'h7
`define SEBS_ACK_SLOT      4'h8
`define SEBS_START_BIT     4'hF

// Programming time
`define SEBS_PROG_TIME_MS  8
`define SEBS_CLK_MHZ       200
`define SEBS_PROG_CYCLES   (`SEBS_PROG_TIME_MS * 1000 * `SEBS_CLK_MHZ)
`define SEBS_PROG_CNT_W    21

// Write path buffer
`define SEBS_FIFO_DEPTH    4
`define SEBS_FIFO_AW       2
`define SEBS_FIFO_W        12

`endif

// ---- core/sebs_eeprom_slave.v ----
// Two-wire bus slave of a 2048 x 8 serial EEPROM, with its memory,
// page buffer, write FIFO and self-timed programming engine.
// Assumes bus pins come from outside this clock domain; SDA is open drain.
`timescale 1ns/10ps
`include "sebs_consts.vh"

module sebs_fifo
#(
   parameter W  = 12,
   parameter D  = 4,
   parameter AW = 2
)
(
   input  wire         i_clk,
   input  wire         i_reset,
   input  wire         i_in_valid,
   output wire         o_in_ready,
   input  wire [W-1:0] i_in_data,
   output wire         o_out_valid,
   input  wire         i_out_ready,
   output wire [W-1:0] o_out_data
);
   localparam [AW:0] FULL = D[AW:0];
   reg [W-1:0]  store [0:D-1];
   reg [AW-1:0] wp_q;
   reg [AW-1:0] rp_q;
   reg [AW:0]   cnt_q;
   wire         push;
   wire         pop;

   assign o_in_ready  = (cnt_q != FULL);
   assign o_out_valid = (cnt_q != {(AW+1){1'b0}});
   assign o_out_data  = store[rp_q];
   assign push        = i_in_valid && o_in_ready;
   assign pop         = o_out_valid && i_out_ready;

   always @(posedge i_clk)
   begin
      if (push)
         store[wp_q] <= i_in_data;
   end

   always @(posedge i_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         wp_q  <= {AW{1'b0}};
         rp_q  <= {AW{1'b0}};
         cnt_q <= {(AW+1){1'b0}};
      end
      else
      begin
         if (push)
            wp_q <= wp_q + 1'b1;
         if (pop)
            rp_q <= rp_q + 1'b1;
         if (push && !pop)
            cnt_q <= cnt_q + 1'b1;
         else if (pop && !push)
            cnt_q <= cnt_q - 1'b1;
      end
   end
endmodule // sebs_fifo

// Summary of operation
// - Command bits 6..4 must match select pins
// - Middle select bit compares against inverted pin
// - Command bit 0: zero write, one read
// - Write command bits 3..1 give upper address
// - Next byte after write command loads low address
// - Read continues while master acknowledges
// - START and STOP are SDA edges, SCL high
// - STOP after write starts programming, else standby
// - Standby after STOP or programming completes
// - Receiver pulls SDA low in ninth clock
// - Data changes on SCL low, MSB first
// - Acknowledge addressed command, address, data bytes
// - Counter advances per write byte and read
// - Byte write buffered until STOP programs it
// - Programming erases selected bytes, then writes them
// - Programming cycle ends within 8 ms
// - Page write accepts one to sixteen bytes
// - Page write advances only word in page bits
// - Unaddressed page bytes are left untouched
// - Memory holds 2048 bytes, 128 pages of 16
// - Protect pin high at STOP blocks the programming cycle
// - No command acknowledge while programming runs
// - Sequential read wraps top address to zero
// - Repeated START abandons pending write, keeps address
module sebs_eeprom_slave
#(
   parameter PROG_CYCLES = `SEBS_PROG_CYCLES
)
(
   input  wire i_clk,
   input  wire i_reset,
   input  wire i_scl,
   input  wire i_sda,
   output wire o_sda_out,
   output reg  o_sda_oe,
   input  wire i_select_pin_0,
   input  wire i_select_pin_1,
   input  wire i_select_pin_2,
   input  wire i_protect_pin,
   output reg  o_busy,
   output wire o_standby
);
   localparam [4:0] ST_IDLE  = 5'h01;
   localparam [4:0] ST_CMD   = 5'h02;
   localparam [4:0] ST_ADDR  = 5'h04;
   localparam [4:0] ST_WDATA = 5'h08;
   localparam [4:0] ST_RDATA = 5'h10;
   localparam integer PROG_LAST_I = PROG_CYCLES - 1;
   localparam [`SEBS_PROG_CNT_W-1:0] PROG_LAST =
      PROG_LAST_I[`SEBS_PROG_CNT_W-1:0];
   localparam [`SEBS_PROG_CNT_W-1:0] ERASE_END = 21'h00000F;
   localparam [`SEBS_PROG_CNT_W-1:0] WRITE_END = 21'h00001F;

   reg [7:0]  mem [0:`SEBS_MEM_WORDS-1];
   reg [7:0]  page_buf [0:`SEBS_PAGE_BYTES-1];

   // Two-stage synchronisers plus one history stage for edges
   reg [5:0]  pin_s1_q;
   reg [5:0]  pin_s2_q;
   reg        scl_h_q;
   reg        sda_h_q;

   reg [4:0]  st_q;
   reg [3:0]  bit_q;
   reg [7:0]  rx_q;
   reg [7:0]  tx_q;
   reg        mack_q;
   reg        pend_q;
   reg        req_q;
   reg [10:0] addr_q;
   reg [15:0] mask_q;
   reg        clr_mask;
   reg [`SEBS_PROG_CNT_W-1:0] pcnt_q;

   wire scl = pin_s2_q[0];
   wire sda = pin_s2_q[1];
   wire sel0 = pin_s2_q[2];
   wire sel1 = pin_s2_q[3];
   wire sel2 = pin_s2_q[4];
   wire prot = pin_s2_q[5];

   wire start_ev = scl && scl_h_q && sda_h_q && !sda;
   wire stop_ev  = scl && scl_h_q && !sda_h_q && sda;
   wire scl_rise = scl && !scl_h_q && !start_ev && !stop_ev;
   wire scl_fall = !scl && scl_h_q;
   wire active   = (st_q != ST_IDLE);
   wire byte_end = scl_fall && active && bit_q == `SEBS_LAST_DATA_BIT;
   wire ack_end  = scl_fall && active && bit_q == `SEBS_ACK_SLOT;

   wire cmd_match = rx_q[`SEBS_CMD_FIXED_BIT]
      && rx_q[`SEBS_CMD_SEL2_BIT] == sel2
      && rx_q[`SEBS_CMD_SEL1_BIT] == !sel1
      && rx_q[`SEBS_CMD_SEL0_BIT] == sel0
      && !o_busy && !req_q;

   wire        fifo_in_ready;
   wire        fifo_out_valid;
   wire [11:0] fifo_out_data;
   wire        push = byte_end && st_q == ST_WDATA;
   wire        drain = fifo_out_valid && !o_busy;
   wire [3:0]  prog_idx = pcnt_q[3:0];
   wire [10:0] prog_addr = {addr_q[10:4], prog_idx};

   // Open drain: only ever pulls low
   assign o_sda_out = 1'b0;
   assign o_standby = (st_q == ST_IDLE) && !o_busy && !req_q;

   sebs_fifo
   #(
      .W  (`SEBS_FIFO_W),
      .D  (`SEBS_FIFO_DEPTH),
      .AW (`SEBS_FIFO_AW)
   )
   u_fifo
   (
      .i_clk       (i_clk),
      .i_reset     (i_reset),
      .i_in_valid  (push),
      .o_in_ready  (fifo_in_ready),
      .i_in_data   ({addr_q[3:0], rx_q}),
      .o_out_valid (fifo_out_valid),
      .i_out_ready (!o_busy),
      .o_out_data  (fifo_out_data)
   );

   always @(posedge i_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         pin_s1_q <= 6'h3F;
         pin_s2_q <= 6'h3F;
         scl_h_q  <= 1'b1;
         sda_h_q  <= 1'b1;
      end
      else
      begin
         pin_s1_q <= {i_protect_pin, i_select_pin_2, i_select_pin_1,
                      i_select_pin_0, i_sda, i_scl};
         pin_s2_q <= pin_s1_q;
         scl_h_q  <= pin_s2_q[0];
         sda_h_q  <= pin_s2_q[1];
      end
   end

   // Bus protocol engine
   always @(posedge i_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         st_q     <= ST_IDLE;
         bit_q    <= 4'h0;
         rx_q     <= 8'h00;
         tx_q     <= 8'h00;
         mack_q   <= 1'b0;
         pend_q   <= 1'b0;
         addr_q   <= 11'h000;
         o_sda_oe <= 1'b0;
         clr_mask <= 1'b0;
      end
      else
      begin
         clr_mask <= 1'b0;
         if (start_ev)
         begin
            st_q     <= ST_CMD;
            // The START's own SCL fall wraps this to zero
            bit_q    <= `SEBS_START_BIT;
            o_sda_oe <= 1'b0;
            pend_q   <= 1'b0;
         end
         else if (stop_ev)
         begin
            st_q     <= ST_IDLE;
            o_sda_oe <= 1'b0;
            pend_q   <= 1'b0;
         end
         else if (scl_rise && active)
         begin
            if (bit_q == `SEBS_ACK_SLOT)
               mack_q <= !sda;
            else
               rx_q <= {rx_q[6:0], sda};
         end
         else if (byte_end)
         begin
            bit_q <= `SEBS_ACK_SLOT;
            case (st_q)
               ST_CMD:
               begin
                  if (cmd_match)
                  begin
                     o_sda_oe <= 1'b1;
                     if (!rx_q[`SEBS_CMD_RW_BIT])
                     begin
                        addr_q[10:8] <= rx_q[`SEBS_CMD_UPPER_HI:
                                             `SEBS_CMD_UPPER_LO];
                        clr_mask <= 1'b1;
                     end
                  end
                  else
                  begin
                     st_q     <= ST_IDLE;
                     o_sda_oe <= 1'b0;
                  end
               end
               ST_ADDR:
               begin
                  addr_q[7:0] <= rx_q;
                  o_sda_oe    <= 1'b1;
               end
               ST_WDATA:
               begin
                  // A full buffer answers with no acknowledge
                  if (fifo_in_ready)
                  begin
                     o_sda_oe    <= 1'b1;
                     addr_q[3:0] <= addr_q[3:0] + 1'b1;
                     pend_q      <= 1'b1;
                  end
               end
               ST_RDATA:
                  o_sda_oe <= 1'b0;
               default:
                  o_sda_oe <= 1'b0;
            endcase
         end
         else if (ack_end)
         begin
            bit_q    <= 4'h0;
            o_sda_oe <= 1'b0;
            case (st_q)
               ST_CMD:
               begin
                  if (rx_q[`SEBS_CMD_RW_BIT])
                  begin
                     st_q     <= ST_RDATA;
                     tx_q     <= mem[addr_q];
                     o_sda_oe <= !mem[addr_q][7];
                     addr_q   <= addr_q + 1'b1;
                  end
                  else
                     st_q <= ST_ADDR;
               end
               ST_ADDR:
                  st_q <= ST_WDATA;
               ST_WDATA:
                  st_q <= ST_WDATA;
               ST_RDATA:
               begin
                  if (mack_q)
                  begin
                     tx_q     <= mem[addr_q];
                     o_sda_oe <= !mem[addr_q][7];
                     addr_q   <= addr_q + 1'b1;
                  end
                  else
                     st_q <= ST_IDLE;
               end
               default:
                  st_q <= ST_IDLE;
            endcase
         end
         else if (scl_fall && active)
         begin
            bit_q <= bit_q + 1'b1;
            if (st_q == ST_RDATA)
            begin
               o_sda_oe <= !tx_q[6];
               tx_q     <= {tx_q[6:0], 1'b0};
            end
         end
      end
   end

   // Programming request, timer and page mask
   always @(posedge i_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         req_q  <= 1'b0;
         o_busy <= 1'b0;
         pcnt_q <= {`SEBS_PROG_CNT_W{1'b0}};
         mask_q <= 16'h0000;
      end
      else
      begin
         if (stop_ev && pend_q && !prot)
            req_q <= 1'b1;
         else if (req_q && !fifo_out_valid)
         begin
            // Waits for the buffer to empty so every byte is programmed
            req_q  <= 1'b0;
            o_busy <= 1'b1;
            pcnt_q <= {`SEBS_PROG_CNT_W{1'b0}};
         end
         if (o_busy)
         begin
            pcnt_q <= pcnt_q + 1'b1;
            if (pcnt_q == PROG_LAST)
            begin
               o_busy <= 1'b0;
               mask_q <= 16'h0000;
            end
         end
         else if (clr_mask)
            mask_q <= 16'h0000;
         else if (drain)
            mask_q[fifo_out_data[11:8]] <= 1'b1;
      end
   end

   always @(posedge i_clk)
   begin
      if (drain)
         page_buf[fifo_out_data[11:8]] <= fifo_out_data[7:0];
      if (o_busy && mask_q[prog_idx])
      begin
         if (pcnt_q <= ERASE_END)
            mem[prog_addr] <= `SEBS_ERASED_BYTE;
         else if (pcnt_q <= WRITE_END)
            mem[prog_addr] <= page_buf[prog_idx];
      end
   end
endmodule // sebs_eeprom_slave

// ---- sim/sebs_bus_master.sv ----
// Behavioural two-wire bus master driving SCL and SDA.
// Assumes the bench resolves wired-AND SDA onto i_sda.
`timescale 1ns/10ps
module sebs_bus_master
(
   input  wire i_sda,
   output reg  o_scl,
   output reg  o_sda
);
   // Quarter bus period; raised by the bench for a slow bus
   int q_ns = 16;
   initial
   begin
      o_scl = 1'b1;
      o_sda = 1'b1;
   end
   task automatic go_start;
      o_sda = 1'b1;
      #q_ns;
      o_scl = 1'b1;
      #q_ns;
      o_sda = 1'b0;
      #q_ns;
      o_scl = 1'b0;
      #q_ns;
   endtask
   task automatic go_stop;
      o_sda = 1'b0;
      #q_ns;
      o_scl = 1'b1;
      #q_ns;
      o_sda = 1'b1;
      #q_ns;
   endtask
   // Nine clocks; a released bit reads back what the slave drives
   task automatic xfer(input [7:0] d, input mack,
                       output [7:0] rd, output sack);
      logic [8:0] sh;
      sh = {d, mack};
      for (int i = 8; i >= 0; i--)
      begin
         o_sda = sh[i];
         #q_ns;
         o_scl = 1'b1;
         #q_ns;
         sh[i] = i_sda;
         #q_ns;
         o_scl = 1'b0;
         #q_ns;
      end
      rd = sh[8:1];
      sack = ~sh[0];
   endtask
endmodule // sebs_bus_master

// ---- sim/sebs_eeprom_slave_assertions.sv ----
// Port-level checks for the EEPROM bus slave.
// Assumes bus pins change asynchronously to i_clk.
`timescale 1ns/10ps
module sebs_eeprom_slave_assertions
#(
   parameter PROG_CYCLES = 64
)
(
   input wire i_clk,
   input wire i_reset,
   input wire i_scl,
   input wire i_sda,
   input wire o_sda_out,
   input wire o_sda_oe,
   input wire i_select_pin_0,
   input wire i_select_pin_1,
   input wire i_select_pin_2,
   input wire i_protect_pin,
   input wire o_busy,
   input wire o_standby
);
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_reset);
   reg [5:0] scl_h_q;
   int       bcnt_q;
   // Six samples of SCL span the sync delay on the answer
   always @(posedge i_clk or posedge i_reset)
      if (i_reset)
      begin
         scl_h_q <= 6'h3F;
         bcnt_q  <= 0;
      end
      else
      begin
         scl_h_q <= {scl_h_q[4:0], i_scl};
         bcnt_q  <= o_busy ? bcnt_q + 1 : 0;
      end
   sequence s_start;
      $fell(i_sda) && i_scl;
   endsequence
   sequence s_idle_bus;
      i_scl && i_sda;
   endsequence
   property p_drain;
      o_sda_out == 1'b0;
   endproperty
   property p_oe_edge;
      $changed(o_sda_oe) |-> scl_h_q[5] && !i_scl;
   endproperty
   property p_start_rel;
      s_start |=> !o_sda_oe [*8];
   endproperty
   property p_idle;
      o_standby |-> !o_busy && !o_sda_oe;
   endproperty
   property p_busy_quiet;
      o_busy |-> !o_sda_oe;
   endproperty
   // Busy lasts PROG_CYCLES clocks, the buffer drains before it; 16 is spare
   property p_busy_len;
      o_busy |-> bcnt_q < PROG_CYCLES + 16;
   endproperty
   property p_prog_stop;
      $rose(o_busy) |-> s_idle_bus;
   endproperty
   property p_protect;
      $rose(o_busy) |-> !i_protect_pin;
   endproperty
   a_drain: assert property (p_drain)
      else $error("sda output value not low");
   a_oe_edge: assert property (p_oe_edge)
      else $error("sda enable moved outside scl low");
   a_start_rel: assert property (p_start_rel)
      else $error("sda held after start");
   a_idle: assert property (p_idle)
      else $error("standby while active");
   a_busy_quiet: assert property (p_busy_quiet)
      else $error("sda driven while busy");
   a_busy_len: assert property (p_busy_len)
      else $error("programming too long");
   a_prog_stop: assert property (p_prog_stop)
      else $error("busy without stop");
   a_protect: assert property (p_protect)
      else $error("busy while protected");
endmodule // sebs_eeprom_slave_assertions
bind sebs_eeprom_slave sebs_eeprom_slave_assertions #(
   .PROG_CYCLES(PROG_CYCLES)) u_sebs_eeprom_slave_assertions (
   .i_clk(i_clk), .i_reset(i_reset), .i_scl(i_scl), .i_sda(i_sda),
   .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe), .o_busy(o_busy),
   .i_select_pin_0(i_select_pin_0), .i_select_pin_1(i_select_pin_1),
   .i_select_pin_2(i_select_pin_2), .i_protect_pin(i_protect_pin),
   .o_standby(o_standby));

// ---- sim/sebs_eeprom_slave_test.sv ----
// Self-checking bench for the EEPROM bus slave.
// Assumes the behavioural master and a short programming time.
`timescale 1ns/10ps
module sebs_eeprom_slave_test;
   localparam PROG = 400;
   localparam [2:0] SEL = 3'b110;
   logic clk, reset, protect, oe, sda_out, busy, standby, m_scl, m_sda;
   logic [2:0] sel;
   logic [7:0] d[$];
   logic [7:0] e[$];
   logic [7:0] mk[4] = '{8'h80, 8'h40, 8'h20, 8'h10};
   int failures;
   int n_compared;
   wire sda = m_sda & (oe ? sda_out : 1'b1);
   always #2.5 clk = ~clk;
   sebs_bus_master u_sebs_bus_master (.i_sda(sda), .o_scl(m_scl),
      .o_sda(m_sda));
   sebs_eeprom_slave #(.PROG_CYCLES(PROG)) u_sebs_eeprom_slave (
      .i_clk(clk), .i_reset(reset), .i_scl(m_scl), .i_sda(sda),
      .o_sda_out(sda_out), .o_sda_oe(oe), .i_select_pin_0(sel[0]),
      .i_select_pin_1(sel[1]), .i_select_pin_2(sel[2]),
      .i_protect_pin(protect), .o_busy(busy), .o_standby(standby));
   task automatic chk(input string nm, input [7:0] seen, input [7:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         failures++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic give_verdict;
      if (failures == 0 && n_compared > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   function automatic [7:0] cmd(input rw, input [2:0] up);
      return {1'b1, SEL[2], ~SEL[1], SEL[0], up, rw};
   endfunction
   task automatic send(input [7:0] b, input ack);
      logic [7:0] r;
      logic a;
      u_sebs_bus_master.xfer(b, 1'b1, r, a);
      chk("ack", {7'h0, a}, {7'h0, ack});
   endtask
   task automatic wait_busy(input logic lvl, input int lim);
      for (int k = 0; k < lim && busy !== lvl; k++)
         @(negedge clk);
      chk("busy", {7'h0, busy}, {7'h0, lvl});
      if (busy !== lvl)
         give_verdict();
   endtask
   task automatic wr(input [10:0] a, input bit poll, input bit prog);
      u_sebs_bus_master.go_start();
      send(cmd(1'b0, a[10:8]), 1'b1);
      send(a[7:0], 1'b1);
      foreach (d[i])
         send(d[i], 1'b1);
      u_sebs_bus_master.go_stop();
      @(negedge clk);
      if (prog)
      begin
         wait_busy(1'b1, 16);
         if (poll)
         begin
            u_sebs_bus_master.go_start();
            send(cmd(1'b1, 3'h0), 1'b0);
            u_sebs_bus_master.go_stop();
         end
         wait_busy(1'b0, PROG + 16);
      end
      else
      begin
         repeat (20) @(negedge clk);
         chk("busy", {7'h0, busy}, 8'h00);
      end
   endtask
   task automatic rd(input [10:0] a);
      logic [7:0] r;
      logic s;
      u_sebs_bus_master.go_start();
      send(cmd(1'b0, a[10:8]), 1'b1);
      send(a[7:0], 1'b1);
      u_sebs_bus_master.go_start();
      // Upper bits inverted: a read must ignore them
      send(cmd(1'b1, ~a[10:8]), 1'b1);
      foreach (e[i])
      begin
         u_sebs_bus_master.xfer(8'hFF, i == e.size() - 1, r, s);
         chk("data", r, e[i]);
      end
      u_sebs_bus_master.go_stop();
      repeat (4) @(negedge clk);
      chk("standby", {7'h0, standby}, 8'h01);
   endtask
   initial
   begin
      clk = 1'b0;
      reset = 1'b1;
      protect = 1'b0;
      sel = SEL;
      failures = 0;
      n_compared = 0;
      repeat (2) @(negedge clk);
      reset = 1'b0;
      repeat (4) @(negedge clk);
      foreach (mk[i])
      begin
         u_sebs_bus_master.go_start();
         send(cmd(1'b0, 3'h0) ^ mk[i], 1'b0);
         send(8'h00, 1'b0);
         u_sebs_bus_master.go_stop();
      end
      d = {8'h3C};
      wr(11'h7FF, 1'b1, 1'b1);
      d = {8'hC3};
      wr(11'h000, 1'b0, 1'b1);
      e = {8'h3C, 8'hC3};
      rd(11'h7FF);
      d = {};
      repeat (16) d.push_back(8'hAA);
      wr(11'h130, 1'b0, 1'b1);
      d = {8'h11, 8'h22, 8'h33, 8'h44};
      wr(11'h13E, 1'b0, 1'b1);
      protect = 1'b1;
      u_sebs_bus_master.q_ns = 40;
      d = {8'h55};
      wr(11'h131, 1'b0, 1'b0);
      protect = 1'b0;
      u_sebs_bus_master.q_ns = 16;
      e = {8'h33, 8'h44};
      repeat (12) e.push_back(8'hAA);
      e.push_back(8'h11);
      e.push_back(8'h22);
      rd(11'h130);
      give_verdict();
   end
endmodule // sebs_eeprom_slave_test
